// file: iab_pkg.sv
package iab_pkg;
    localparam int CPU_ADDR_W  = 23;
    localparam int LA_W        = 7;
    localparam int LA_LSB      = 17;
    localparam int SA_W        = 11;
    localparam int SA_LSB      = 9;
    localparam int CODE_W      = 3;
    localparam int ACK_W       = 8;
    localparam int SYNC_STAGES = 3;
    localparam logic [LA_W-1:0] LA_RST  = 7'h00;
    localparam logic [SA_W-1:0] SA_RST  = 11'h000;
    localparam logic [ACK_W-1:0] ACK_IDLE = 8'hff;
    typedef enum logic [1:0] {
        IAB_DIR_IN,
        IAB_DIR_DRIVE,
        IAB_DIR_FLOAT
    } iab_dir_t;
endpackage

// file: iab_sync.sv
`timescale 1ns/100ps
module iab_sync #(
    parameter int W     = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output logic [W-1:0]      o_sync
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q;
    logic [W-1:0] s1_d, s2_d, s3_d, out_d;

    // a change counts once stages two and three agree
    always_comb begin
        s1_d  = i_async;
        s2_d  = s1_q;
        s3_d  = s2_q;
        out_d = out_q;
        for (int b = 0; b < W; b++) begin
            if (s2_q[b] == s3_q[b]) begin
                out_d[b] = s3_q[b];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            s1_q  <= RST_VAL;
            s2_q  <= RST_VAL;
            s3_q  <= RST_VAL;
            out_q <= RST_VAL;
        end else begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            out_q <= out_d;
        end
    end

    assign o_sync = out_q;
endmodule

// file: iab_top.sv
`timescale 1ns/100ps
module iab_top
    import iab_pkg::*;
(
    input  wire logic                  i_mclk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_reset_drive,
    input  wire logic                  i_hold_ack,
    input  wire logic                  i_bus_master_n,
    input  wire logic                  i_refresh_n,
    input  wire logic [CPU_ADDR_W:1]   i_cpu_addr,
    output logic [CPU_ADDR_W:1]        o_cpu_addr,
    output logic                       o_cpu_addr_oe,
    input  wire logic                  i_cpu_bhe_n,
    output logic                       o_cpu_bhe_n,
    output logic                       o_cpu_bhe_oe,
    input  wire logic [LA_W-1:0]       i_latchable_upper_addr,
    output logic [LA_W-1:0]            o_latchable_upper_addr,
    output logic                       o_latchable_upper_addr_oe,
    input  wire logic [SA_W-1:0]       i_system_addr_upper,
    output logic [SA_W-1:0]            o_system_addr_upper,
    output logic                       o_system_addr_upper_oe,
    input  wire logic [8:1]            i_system_addr_low,
    output logic [8:1]                 o_system_addr_low,
    output logic                       o_system_addr_low_oe,
    input  wire logic                  i_system_addr_bit0,
    input  wire logic                  i_sys_bhe_n,
    output logic                       o_sys_bhe_n,
    output logic                       o_sys_bhe_oe,
    input  wire logic                  i_early_addr_latch_strobe_n,
    input  wire logic                  i_ack_decoder_enable_n,
    input  wire logic [CODE_W-1:0]     i_dma_channel_code,
    output logic [ACK_W-1:0]           o_dma_ack_n,
    output logic [LA_W-1:0]            o_latched_la,
    output logic [SA_W-1:0]            o_latched_sa,
    output logic                       o_latched_sbhe_n,
    output logic [8:0]                 o_sa_low_bits
);
    localparam int SW = 6 + CODE_W + LA_W + SA_W + 8 + 1 + CPU_ADDR_W + 1;

    logic [SW-1:0]         raw;
    logic [SW-1:0]         syn;
    logic                  s_rstdrv;
    logic                  s_hlda;
    logic                  s_master_n;
    logic                  s_refresh_n;
    logic                  s_strobe_n;
    logic                  s_ack_decoder_enable_n_n;
    logic                  s_sbhe_n;
    logic                  s_cpu_bhe_n;
    logic [CODE_W-1:0]     s_code;
    logic [LA_W-1:0]       s_la;
    logic [SA_W-1:0]       s_sa;
    logic [8:1]            s_sal;
    logic [CPU_ADDR_W:1]   s_cpu_addr;
    logic [ACK_W-1:0]      ack_hit;

    // every pin but i_system_addr_bit0 crosses into i_mclk through four flops; reset holds reset drive asserted,
    // so the outputs stay quiet until the first real pin levels have passed
    assign raw = {i_reset_drive,
                  i_hold_ack,
                  i_bus_master_n,
                  i_refresh_n,
                  i_early_addr_latch_strobe_n,
                  i_ack_decoder_enable_n,
                  i_dma_channel_code,
                  i_latchable_upper_addr,
                  i_system_addr_upper,
                  i_system_addr_low,
                  i_sys_bhe_n,
                  i_cpu_addr,
                  i_cpu_bhe_n};
    iab_sync #(
        .W       (SW),
        .RST_VAL ({6'b100111, {(SW-7){1'b0}}, 1'b1})
    ) u_sync (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_async (raw),
        .o_sync  (syn)
    );
    assign {s_rstdrv,
            s_hlda,
            s_master_n,
            s_refresh_n,
            s_strobe_n,
            s_ack_decoder_enable_n_n,
            s_code,
            s_la,
            s_sa,
            s_sal,
            s_sbhe_n,
            s_cpu_addr,
            s_cpu_bhe_n} = syn;

    // one decode term per acknowledge: channels 0-3 answer codes 1-4,
    // channels 5-7 answer their own code, channel 4 and code 0 answer nothing
    for (genvar ch = 0; ch < ACK_W; ch++) begin : g_ack
        localparam logic [CODE_W-1:0] CH_CODE = (ch < 4) ? CODE_W'(ch + 1) : CODE_W'(ch);
        assign ack_hit[ch] = (ch != 4) && (s_code == CH_CODE);
    end

    // direction state
    iab_dir_t          sys_dir_q, sys_dir_d;
    logic              cpu_oe_q, cpu_oe_d;
    logic              bhe_oe_q, bhe_oe_d;
    logic [ACK_W-1:0]  ack_q, ack_d;
    logic [CPU_ADDR_W:1] cpu_out_q, cpu_out_d;
    logic              bhe_out_q, bhe_out_d;
    logic [LA_W-1:0]   la_out_q, la_out_d;
    logic [SA_W-1:0]   sa_out_q, sa_out_d;
    logic [8:1]        sal_out_q, sal_out_d;
    logic              sbhe_out_q, sbhe_out_d;
    logic [LA_W-1:0]   la_lat_q, la_lat_d;
    logic [SA_W-1:0]   sa_lat_q, sa_lat_d;
    logic              sbhe_lat_q, sbhe_lat_d;
    logic              strobe_prev_q, strobe_prev_d;

    always_comb begin
        sys_dir_d = IAB_DIR_IN;
        cpu_oe_d  = 1'b0;
        bhe_oe_d  = 1'b0;
        ack_d     = ACK_IDLE;
        if (!s_rstdrv) begin
            if (s_hlda && !s_refresh_n) begin
                sys_dir_d = IAB_DIR_FLOAT;
            end else if (!s_hlda && s_refresh_n) begin
                sys_dir_d = IAB_DIR_DRIVE;
            end
            cpu_oe_d = s_hlda && !s_master_n && s_refresh_n;
            bhe_oe_d = s_hlda && !s_master_n && s_refresh_n;
            if (s_hlda && !s_ack_decoder_enable_n_n) begin
                ack_d = ~ack_hit;
            end
        end
    end

    // drive values for whichever side the direction group turns on
    always_comb begin
        // a23-a20 come from the latchable bus, a19-a1 from the system bus
        cpu_out_d  = {s_la[LA_W-1 -: CPU_ADDR_W-SA_LSB-SA_W+1], s_sa, s_sal};
        bhe_out_d  = s_sbhe_n;
        la_out_d   = s_cpu_addr[CPU_ADDR_W -: LA_W];
        sa_out_d   = s_cpu_addr[SA_LSB+SA_W-1:SA_LSB];
        sal_out_d  = s_cpu_addr[SA_LSB-1:1];
        sbhe_out_d = s_cpu_bhe_n;
    end

    // captures happen on the strobe's falling edge
    always_comb begin
        strobe_prev_d = s_strobe_n;
        la_lat_d   = la_lat_q;
        sa_lat_d   = sa_lat_q;
        sbhe_lat_d = sbhe_lat_q;
        if (strobe_prev_q && !s_strobe_n) begin
            la_lat_d   = s_la;
            sa_lat_d   = s_sa;
            sbhe_lat_d = s_sbhe_n;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sys_dir_q     <= IAB_DIR_IN;
            cpu_oe_q      <= 1'b0;
            bhe_oe_q      <= 1'b0;
            ack_q         <= ACK_IDLE;
        end else begin
            sys_dir_q     <= sys_dir_d;
            cpu_oe_q      <= cpu_oe_d;
            bhe_oe_q      <= bhe_oe_d;
            ack_q         <= ack_d;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            cpu_out_q     <= '0;
            bhe_out_q     <= 1'b1;
            la_out_q      <= LA_RST;
            sa_out_q      <= SA_RST;
            sal_out_q     <= 8'h00;
            sbhe_out_q    <= 1'b1;
        end else begin
            cpu_out_q     <= cpu_out_d;
            bhe_out_q     <= bhe_out_d;
            la_out_q      <= la_out_d;
            sa_out_q      <= sa_out_d;
            sal_out_q     <= sal_out_d;
            sbhe_out_q    <= sbhe_out_d;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            strobe_prev_q <= 1'b1;
            la_lat_q      <= LA_RST;
            sa_lat_q      <= SA_RST;
            sbhe_lat_q    <= 1'b1;
        end else begin
            strobe_prev_q <= strobe_prev_d;
            la_lat_q      <= la_lat_d;
            sa_lat_q      <= sa_lat_d;
            sbhe_lat_q    <= sbhe_lat_d;
        end
    end

    assign o_cpu_addr                = cpu_out_q;
    assign o_cpu_addr_oe             = cpu_oe_q;
    assign o_cpu_bhe_n               = bhe_out_q;
    assign o_cpu_bhe_oe              = bhe_oe_q;
    assign o_latchable_upper_addr    = la_out_q;
    assign o_latchable_upper_addr_oe = (sys_dir_q == IAB_DIR_DRIVE);
    assign o_system_addr_upper       = sa_out_q;
    assign o_system_addr_upper_oe    = (sys_dir_q == IAB_DIR_DRIVE);
    assign o_system_addr_low         = sal_out_q;
    assign o_system_addr_low_oe      = (sys_dir_q == IAB_DIR_DRIVE);
    assign o_sys_bhe_n               = sbhe_out_q;
    assign o_sys_bhe_oe              = (sys_dir_q == IAB_DIR_DRIVE);
    assign o_dma_ack_n               = ack_q;
    assign o_latched_la              = la_lat_q;
    assign o_latched_sa              = sa_lat_q;
    assign o_latched_sbhe_n          = sbhe_lat_q;
    // bit zero is never driven, only used for local decode
    assign o_sa_low_bits             = {sal_out_q, i_system_addr_bit0};
endmodule

// file: iab_top_monitor.sv
`timescale 1ns/100ps
module iab_top_monitor
    import iab_pkg::*;
(
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_reset_drive,
    input  wire logic                 i_hold_ack,
    input  wire logic                 i_bus_master_n,
    input  wire logic                 i_refresh_n,
    input  wire logic                 o_cpu_addr_oe,
    input  wire logic                 o_cpu_bhe_oe,
    input  wire logic                 o_latchable_upper_addr_oe,
    input  wire logic [LA_W-1:0]      i_latchable_upper_addr,
    input  wire logic [SA_W-1:0]      i_system_addr_upper,
    input  wire logic                 o_system_addr_upper_oe,
    input  wire logic                 o_system_addr_low_oe,
    input  wire logic                 i_system_addr_bit0,
    input  wire logic                 o_sys_bhe_oe,
    input  wire logic                 i_early_addr_latch_strobe_n,
    input  wire logic                 i_ack_decoder_enable_n,
    input  wire logic [CODE_W-1:0]    i_dma_channel_code,
    input  wire logic [ACK_W-1:0]     o_dma_ack_n,
    input  wire logic [LA_W-1:0]      o_latched_la,
    input  wire logic [SA_W-1:0]      o_latched_sa,
    input  wire logic [8:0]           o_sa_low_bits
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    wire              cpu_own = !i_reset_drive && i_hold_ack && !i_bus_master_n && i_refresh_n;
    wire              sys_own = !i_reset_drive && !i_hold_ack && i_refresh_n;
    logic [ACK_W-1:0] ack_exp;
    always_comb begin
        ack_exp = ACK_IDLE;
        if (!i_reset_drive && i_hold_ack && !i_ack_decoder_enable_n && i_dma_channel_code != 3'h0)
            ack_exp[i_dma_channel_code - {2'h0, i_dma_channel_code < 3'h5}] = 1'b0;
    end
    // controls held long enough to pass the input synchronisers
    sequence s_calm;
        $stable({i_reset_drive, i_hold_ack, i_bus_master_n, i_refresh_n, i_ack_decoder_enable_n,
                 i_dma_channel_code})[*7];
    endsequence
    chk_cpu_addr_oe: assert property (s_calm |-> o_cpu_addr_oe == cpu_own)
        else $error("cpu address enable wrong");
    chk_cpu_bhe_oe: assert property (s_calm |-> o_cpu_bhe_oe == cpu_own)
        else $error("cpu byte-high enable wrong");
    chk_la_dir: assert property (s_calm |-> o_latchable_upper_addr_oe == sys_own)
        else $error("latchable address enable wrong");
    chk_sa_dir: assert property (s_calm |-> {o_system_addr_upper_oe, o_system_addr_low_oe} == {2{sys_own}})
        else $error("system address enable wrong");
    chk_sbhe_dir: assert property (s_calm |-> o_sys_bhe_oe == sys_own)
        else $error("system byte-high enable wrong");
    chk_sa_bit_zero: assert property (o_sa_low_bits[0] == i_system_addr_bit0)
        else $error("address bit zero not passed through");
    chk_ack_decode: assert property (s_calm |-> o_dma_ack_n == ack_exp)
        else $error("dma acknowledge decode wrong");
    chk_ack_no_hold: assert property (s_calm ##0 !i_hold_ack |-> o_dma_ack_n == ACK_IDLE)
        else $error("acknowledge without hold acknowledge");
    chk_latch_capture: assert property ($fell(i_early_addr_latch_strobe_n) ##0
        $stable({i_latchable_upper_addr, i_system_addr_upper})[*8]
        |-> {o_latched_la, o_latched_sa} == {i_latchable_upper_addr, i_system_addr_upper})
        else $error("latched address differs from bus");
    cover property (s_calm ##0 cpu_own);
    cover property (s_calm ##0 o_dma_ack_n != ACK_IDLE);
    cover property ($fell(i_early_addr_latch_strobe_n));
endmodule
bind iab_top iab_top_monitor i_mon (.*);

// file: iab_far_side.sv
`timescale 1ns/100ps
module iab_far_side (
    input  wire logic i_mclk,
    input  wire logic i_cycle_start,
    output logic      o_strobe_n
);
    logic [2:0] cnt_q = 3'h0;
    logic [2:0] cnt_d;
    // low for four cycles, then at least four high before the next start
    always_comb begin
        cnt_d = (cnt_q != 3'h0) ? cnt_q - 3'h1 : (i_cycle_start ? 3'h7 : 3'h0);
    end
    always_ff @(posedge i_mclk) begin
        cnt_q <= cnt_d;
    end
    assign o_strobe_n = ~cnt_q[2];
endmodule

// file: test_isa_address_buffer_dack_decoder.sv
`timescale 1ns/100ps
module test_isa_address_buffer_dack_decoder
    import iab_pkg::*;
;
    logic                i_mclk, i_rst_n, i_reset_drive, i_hold_ack, i_bus_master_n, i_refresh_n, cyc_go;
    logic                i_system_addr_bit0, i_ack_decoder_enable_n, i_early_addr_latch_strobe_n, sbhe_far;
    logic                o_cpu_addr_oe, o_cpu_bhe_n, o_cpu_bhe_oe, o_latchable_upper_addr_oe, o_sys_bhe_oe;
    logic                o_system_addr_upper_oe, o_system_addr_low_oe, o_sys_bhe_n, o_latched_sbhe_n;
    logic                i_cpu_bhe_n, i_sys_bhe_n;
    logic [CPU_ADDR_W:1] i_cpu_addr, o_cpu_addr, cpu_far;
    logic [LA_W-1:0]     i_latchable_upper_addr, o_latchable_upper_addr, o_latched_la, la_far;
    logic [SA_W-1:0]     i_system_addr_upper, o_system_addr_upper, o_latched_sa, sa_far;
    logic [8:1]          i_system_addr_low, o_system_addr_low, low_far;
    logic [CODE_W-1:0]   i_dma_channel_code;
    logic [ACK_W-1:0]    o_dma_ack_n;
    logic [8:0]          o_sa_low_bits;
    int                  num_errors = 0;
    int                  checks_done = 0;
    // each shared line shows the device while it drives, the far side otherwise
    assign i_cpu_addr = o_cpu_addr_oe ? o_cpu_addr : cpu_far;
    assign i_cpu_bhe_n = o_cpu_bhe_oe ? o_cpu_bhe_n : sbhe_far;
    assign i_latchable_upper_addr = o_latchable_upper_addr_oe ? o_latchable_upper_addr : la_far;
    assign i_system_addr_upper = o_system_addr_upper_oe ? o_system_addr_upper : sa_far;
    assign i_system_addr_low = o_system_addr_low_oe ? o_system_addr_low : low_far;
    assign i_sys_bhe_n = o_sys_bhe_oe ? o_sys_bhe_n : sbhe_far;
    iab_top i_dut (.*);
    iab_far_side i_far (.i_mclk(i_mclk), .i_cycle_start(cyc_go), .o_strobe_n(i_early_addr_latch_strobe_n));
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    task automatic cmp(input string what, input logic [22:0] exp, input logic [22:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ctl(input logic h, input logic m, input logic r);
        @(posedge i_mclk);
        i_hold_ack <= h;
        i_bus_master_n <= m;
        i_refresh_n <= r;
        i_system_addr_bit0 <= ~i_system_addr_bit0;
        repeat (7) @(posedge i_mclk);
        #1;
    endtask
    task automatic test_modes();
        logic c, s;
        for (int k = 0; k < 8; k++) begin
            ctl(k[2], k[1], k[0]);
            c = k[2] & ~k[1] & k[0];
            s = ~k[2] & k[0];
            cmp("oe", 23'({c, c, s, s, s, s}), 23'({o_cpu_addr_oe, o_cpu_bhe_oe, o_latchable_upper_addr_oe,
                o_system_addr_upper_oe, o_system_addr_low_oe, o_sys_bhe_oe}));
            cmp("sa0", 23'(i_system_addr_bit0), 23'(o_sa_low_bits[0]));
            if (s) cmp("la", 23'({cpu_far[23:17], cpu_far[19:9]}), 23'({o_latchable_upper_addr, o_system_addr_upper}));
            if (c) cmp("bhe", 23'(sbhe_far), 23'(o_cpu_bhe_n));
            if (c) cmp("cpu", 23'({la_far[6:3], sa_far, low_far}), 23'(o_cpu_addr));
            if (s) cmp("sal", 23'({cpu_far[8:1], cpu_far[8:1]}), 23'({o_system_addr_low, o_sa_low_bits[8:1]}));
            if (s) cmp("sbhe", 23'(sbhe_far), 23'(o_sys_bhe_n));
        end
        $display("test modes done");
    endtask
    task automatic test_ack();
        logic [ACK_W-1:0] e;
        for (int k = 0; k < 17; k++) begin
            @(posedge i_mclk);
            i_ack_decoder_enable_n <= k[3];
            i_dma_channel_code <= (k == 16) ? 3'h5 : k[2:0];
            ctl(k != 16, 1'b1, 1'b1);
            e = ACK_IDLE;
            if (k < 8 && k != 0) e[k < 5 ? k - 1 : k] = 1'b0;
            cmp("ack", 23'(e), 23'(o_dma_ack_n));
        end
        $display("test ack done");
    endtask
    task automatic test_latch();
        ctl(1'b1, 1'b0, 1'b1);
        @(posedge i_mclk);
        la_far <= 7'h5a;
        sa_far <= 11'h6c3;
        cyc_go <= 1'b1;
        @(posedge i_mclk);
        cyc_go <= 1'b0;
        ctl(1'b1, 1'b0, 1'b1);
        cmp("latch", 23'({7'h5a, 11'h6c3, 1'b0}), 23'({o_latched_la, o_latched_sa, o_latched_sbhe_n}));
        @(posedge i_mclk);
        la_far <= 7'h25;
        sa_far <= 11'h13c;
        ctl(1'b1, 1'b0, 1'b1);
        cmp("hold", 23'({7'h5a, 11'h6c3, 1'b0}), 23'({o_latched_la, o_latched_sa, o_latched_sbhe_n}));
        $display("test latch done");
    endtask
    task automatic test_rstdrv();
        @(posedge i_mclk);
        i_ack_decoder_enable_n <= 1'b0;
        i_dma_channel_code <= 3'h1;
        ctl(1'b1, 1'b0, 1'b1);
        cmp("pre", 23'h0000fe, 23'(o_dma_ack_n));
        @(posedge i_mclk);
        i_reset_drive <= 1'b1;
        ctl(1'b1, 1'b0, 1'b1);
        cmp("rd_ack", 23'(ACK_IDLE), 23'(o_dma_ack_n));
        ctl(1'b0, 1'b0, 1'b1);
        cmp("rd_oe", 23'h0, 23'({o_cpu_addr_oe, o_latchable_upper_addr_oe, o_system_addr_upper_oe, o_sys_bhe_oe}));
        @(posedge i_mclk);
        i_reset_drive <= 1'b0;
        $display("test rstdrv done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        {i_rst_n, i_reset_drive, i_hold_ack, i_system_addr_bit0, cyc_go, sbhe_far} = 6'h00;
        {i_bus_master_n, i_refresh_n, i_ack_decoder_enable_n} = 3'h7;
        i_dma_channel_code = 3'h0;
        cpu_far = 23'h2b3c5d;
        {la_far, sa_far, low_far} = {7'h4b, 11'h2a5, 8'hc3};
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        test_modes();
        test_ack();
        test_latch();
        test_rstdrv();
        test_done();
    end
    initial begin
        repeat (3000) @(posedge i_mclk);
        num_errors++;
        test_done();
    end
endmodule
